// ---- mpf_port_logic.v ----
`include "mpf_defines.vh"

module mpf_port_logic (
    input  wire         clk,
    input  wire         rst,
    input  wire         ce,
    input  wire         sys_reset_n,
    input  wire         wr_en,
    input  wire [3:0]   wr_sel,
    input  wire [7:0]   wr_data,
    input  wire [3:0]   rd_sel,
    output reg  [7:0]   rd_data_reg,
    input  wire [5:0]   p0_in,
    output reg  [5:0]   p0_out_reg,
    output reg  [5:0]   p0_oe_n_reg,
    output reg  [5:0]   p0_pullup_reg,
    input  wire [1:0]   p1_in,
    output reg  [1:0]   p1_out_reg,
    output reg  [1:0]   p1_oe_n_reg,
    output reg  [1:0]   p1_pullup_reg,
    input  wire [6:0]   p2_in,
    output reg  [6:0]   p2_out_reg,
    output reg  [6:0]   p2_oe_n_reg,
    output reg  [6:0]   p2_pullup_reg,
    input  wire [3:0]   p3_in,
    output reg  [3:0]   p3_out_reg,
    output reg  [3:0]   p3_oe_n_reg,
    output reg  [3:0]   p3_pullup_reg,
    input  wire [3:0]   p5_in,
    output reg  [3:0]   p5_out_reg,
    output reg  [3:0]   p5_oe_n_reg,
    input  wire [7:0]   p6_in,
    output reg  [7:0]   analog_in_sel_reg,
    input  wire         serial_async_sel,
    input  wire         sync_serial_clock_out,
    input  wire         sync_serial_data_out,
    input  wire         async_tx,
    input  wire         two_wire_clock_out,
    input  wire         two_wire_data_out,
    input  wire         timer_a_out,
    input  wire         timer_b_out,
    input  wire         wide_timer_out,
    input  wire         timer_c_out,
    input  wire         buzzer_out,
    input  wire         buzzer_sel,
    output reg          sync_serial_clock_in_reg,
    output reg          async_clock_in_reg,
    output reg          sync_serial_data_in_reg,
    output reg          async_rx_reg,
    output reg          two_wire_clock_in_reg,
    output reg          two_wire_data_in_reg,
    output reg          timer_a_ext_clock_in_reg,
    output reg          sync_serial_select_in_reg,
    output reg          timer_b_ext_clock_in_reg,
    output reg          capture_edge_in_reg,
    output wire [3:0]   ext_irq_in
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // A bit set as output reads back its latch, an input bit reads the pin.
    function [7:0] port_read;
        input [7:0] dir;
        input [7:0] latch;
        input [7:0] pin;
        begin
            port_read = (dir & latch) | (~dir & pin);
        end
    endfunction

    // Open-drain bits only ever drive low, so the enable also carries the data.
    function [7:0] od_oe_n;
        input [7:0] dir;
        input [7:0] val;
        begin
            od_oe_n = ~(dir & ~val);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    reg  [5:0] port0_latch_reg;
    reg  [5:0] port0_direction_reg;
    reg  [1:0] port1_latch_reg;
    reg  [1:0] port1_direction_reg;
    reg  [7:0] low_ports_pullup_reg;
    reg  [6:0] port2_latch_reg;
    reg  [6:0] port2_direction_reg;
    reg  [6:0] port2_pullup_reg;
    reg  [6:0] port2_alt_reg;
    reg  [3:0] port3_latch_reg;
    reg  [3:0] port3_direction_reg;
    reg  [3:0] port3_pullup_reg;
    reg  [11:0] port3_alt_reg;
    reg  [3:0] port5_latch_reg;
    reg  [3:0] port5_direction_reg;
    reg  [7:0] port6_analog_reg;

    // The external reset pin joins the core reset; both are sampled on clk.
    wire       rst_all = rst | ~sys_reset_n;

    always @(posedge clk) begin
        if (rst_all) begin
            port0_latch_reg      <= 6'h00;
            port0_direction_reg  <= 6'h00;
            port1_latch_reg      <= 2'h0;
            port1_direction_reg  <= 2'h0;
            low_ports_pullup_reg <= `MPF_CTRL_RESET;
            port2_latch_reg      <= 7'h00;
            port2_direction_reg  <= 7'h00;
            port2_pullup_reg     <= 7'h00;
            port2_alt_reg        <= 7'h00;
            port3_latch_reg      <= 4'h0;
            port3_direction_reg  <= 4'h0;
            port3_pullup_reg     <= 4'h0;
            port3_alt_reg        <= 12'h000;
            port5_latch_reg      <= 4'h0;
            port5_direction_reg  <= 4'h0;
            port6_analog_reg     <= `MPF_CTRL_RESET;
        end else if (ce && wr_en) begin
            case (wr_sel)
                `MPF_SEL_P0_LATCH:   port0_latch_reg      <= wr_data[5:0];
                `MPF_SEL_P0_DIR:     port0_direction_reg  <= wr_data[5:0];
                `MPF_SEL_P1_LATCH:   port1_latch_reg      <= wr_data[1:0];
                `MPF_SEL_P1_DIR:     port1_direction_reg  <= wr_data[1:0];
                `MPF_SEL_LOW_PULLUP: low_ports_pullup_reg <= wr_data;
                `MPF_SEL_P2_LATCH:   port2_latch_reg      <= wr_data[6:0];
                `MPF_SEL_P2_DIR:     port2_direction_reg  <= wr_data[6:0];
                `MPF_SEL_P2_PULLUP:  port2_pullup_reg     <= wr_data[6:0] & 7'h67;
                `MPF_SEL_P2_ALT:     port2_alt_reg        <= wr_data[6:0];
                `MPF_SEL_P3_LATCH:   port3_latch_reg      <= wr_data[3:0];
                `MPF_SEL_P3_DIR:     port3_direction_reg  <= wr_data[3:0];
                `MPF_SEL_P3_PULLUP:  port3_pullup_reg     <= wr_data[3:0];
                `MPF_SEL_P3_ALT:     port3_alt_reg        <= {wr_data, wr_data[3:0]};
                `MPF_SEL_P5_LATCH:   port5_latch_reg      <= wr_data[3:0];
                `MPF_SEL_P5_DIR:     port5_direction_reg  <= wr_data[3:0];
                `MPF_SEL_P6_CTRL:    port6_analog_reg     <= wr_data;
                default:             port6_analog_reg     <= port6_analog_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive values

    reg  [6:0] p2_val;
    reg  [3:0] p3_val;

    // Alternate output bits take their value from the peripheral, while direction
    // still comes from the direction register, which software must set up.
    always @* begin
        p2_val    = port2_latch_reg;
        if (port2_alt_reg[0]) begin
            p2_val[0] = sync_serial_clock_out;
        end
        if (port2_alt_reg[1]) begin
            p2_val[1] = serial_async_sel ? async_tx : sync_serial_data_out;
        end
        if (port2_alt_reg[3]) begin
            p2_val[3] = two_wire_clock_out;
        end
        if (port2_alt_reg[4]) begin
            p2_val[4] = two_wire_data_out;
        end
        if (port2_alt_reg[6]) begin
            p2_val[6] = timer_a_out;
        end
        p3_val    = port3_latch_reg;
        if (port3_alt_reg[1]) begin
            p3_val[1] = timer_b_out;
        end
        if (port3_alt_reg[2]) begin
            p3_val[2] = wide_timer_out;
        end
        if (port3_alt_reg[3]) begin
            p3_val[3] = buzzer_sel ? buzzer_out : timer_c_out;
        end
    end

    wire [7:0] p2_od_oe_n = od_oe_n({1'b0, port2_direction_reg}, {1'b0, p2_val});
    wire [7:0] p5_od_oe_n = od_oe_n({4'h0, port5_direction_reg}, {4'h0, port5_latch_reg});

    ////////////////////////////////////////////////////////////////////////////
    // Registered pin outputs

    always @(posedge clk) begin
        if (rst_all) begin
            p0_out_reg    <= 6'h00;
            p0_oe_n_reg   <= 6'h3F;
            p0_pullup_reg <= 6'h00;
            p1_out_reg    <= 2'h0;
            p1_oe_n_reg   <= 2'h3;
            p1_pullup_reg <= 2'h0;
            p2_out_reg    <= 7'h00;
            p2_oe_n_reg   <= 7'h7F;
            p2_pullup_reg <= 7'h00;
            p3_out_reg    <= 4'h0;
            p3_oe_n_reg   <= 4'hF;
            p3_pullup_reg <= 4'h0;
            p5_out_reg    <= 4'h0;
            p5_oe_n_reg   <= 4'hF;
            analog_in_sel_reg <= 8'h00;
        end else if (ce) begin
            p0_out_reg    <= port0_latch_reg;
            p0_oe_n_reg   <= ~port0_direction_reg;
            p0_pullup_reg <= low_ports_pullup_reg[5:0] & ~port0_direction_reg;
            p1_out_reg    <= port1_latch_reg;
            p1_oe_n_reg   <= ~port1_direction_reg;
            p1_pullup_reg <= low_ports_pullup_reg[`MPF_LOWPU_P1_MSB:`MPF_LOWPU_P1_LSB] &
                             ~port1_direction_reg;
            // Open-drain bits put out 0 always and drive only through the enable.
            p2_out_reg    <= p2_val & 7'h67;
            p2_oe_n_reg   <= {~port2_direction_reg[6:5],
                              p2_od_oe_n[`MPF_P2_OD_SDA:`MPF_P2_OD_SCL],
                              ~port2_direction_reg[2:0]};
            p2_pullup_reg <= port2_pullup_reg & 7'h67;
            p3_out_reg    <= p3_val;
            p3_oe_n_reg   <= ~port3_direction_reg;
            p3_pullup_reg <= port3_pullup_reg;
            p5_out_reg    <= 4'h0;
            p5_oe_n_reg   <= p5_od_oe_n[3:0];
            analog_in_sel_reg <= port6_analog_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Inputs routed to peripherals

    // Unselected peripheral inputs idle high so a serial or timer input
    // never sees a phantom edge while the pin serves as a plain port.
    always @(posedge clk) begin
        if (rst_all) begin
            sync_serial_clock_in_reg  <= 1'b1;
            async_clock_in_reg        <= 1'b1;
            sync_serial_data_in_reg   <= 1'b1;
            async_rx_reg              <= 1'b1;
            two_wire_clock_in_reg     <= 1'b1;
            two_wire_data_in_reg      <= 1'b1;
            timer_a_ext_clock_in_reg  <= 1'b1;
            sync_serial_select_in_reg <= 1'b1;
            timer_b_ext_clock_in_reg  <= 1'b1;
            capture_edge_in_reg       <= 1'b1;
        end else if (ce) begin
            sync_serial_clock_in_reg  <= ~port2_alt_reg[0] | p2_in[0];
            async_clock_in_reg        <= ~port2_alt_reg[0] | p2_in[0];
            sync_serial_data_in_reg   <= ~port2_alt_reg[2] | p2_in[2];
            async_rx_reg              <= ~port2_alt_reg[2] | p2_in[2];
            two_wire_clock_in_reg     <= ~port2_alt_reg[3] | p2_in[3];
            two_wire_data_in_reg      <= ~port2_alt_reg[4] | p2_in[4];
            timer_a_ext_clock_in_reg  <= ~port2_alt_reg[5] | p2_in[5];
            sync_serial_select_in_reg <= ~port2_alt_reg[5] | p2_in[5];
            timer_b_ext_clock_in_reg  <= ~port3_alt_reg[0] | p3_in[0];
            capture_edge_in_reg       <= ~port3_alt_reg[0] | p3_in[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External interrupt edge detection

    mpf_edge_det #(
        .N          (4)
    ) u_edge (
        .clk        (clk),
        .rst        (rst_all),
        .ce         (ce),
        .enable     (port3_alt_reg[`MPF_P3ALT_EN_MSB:0]),
        .edge_sel   (port3_alt_reg[11:`MPF_P3ALT_EDGE_LSB]),
        .level      (p3_in),
        .pulse_reg  (ext_irq_in)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read-back

    reg  [7:0] rd_next;

    always @* begin
        case (rd_sel)
            `MPF_SEL_P0_LATCH:   rd_next = port_read({2'h0, port0_direction_reg},
                                                     {2'h0, port0_latch_reg}, {2'h0, p0_in});
            `MPF_SEL_P0_DIR:     rd_next = {2'h0, port0_direction_reg};
            `MPF_SEL_P1_LATCH:   rd_next = port_read({6'h00, port1_direction_reg},
                                                     {6'h00, port1_latch_reg}, {6'h00, p1_in});
            `MPF_SEL_P1_DIR:     rd_next = {6'h00, port1_direction_reg};
            `MPF_SEL_LOW_PULLUP: rd_next = low_ports_pullup_reg;
            `MPF_SEL_P2_LATCH:   rd_next = port_read({1'b0, port2_direction_reg},
                                                     {1'b0, port2_latch_reg}, {1'b0, p2_in});
            `MPF_SEL_P2_DIR:     rd_next = {1'b0, port2_direction_reg};
            `MPF_SEL_P2_PULLUP:  rd_next = {1'b0, port2_pullup_reg};
            `MPF_SEL_P2_ALT:     rd_next = {1'b0, port2_alt_reg};
            `MPF_SEL_P3_LATCH:   rd_next = port_read({4'h0, port3_direction_reg},
                                                     {4'h0, port3_latch_reg}, {4'h0, p3_in});
            `MPF_SEL_P3_DIR:     rd_next = {4'h0, port3_direction_reg};
            `MPF_SEL_P3_PULLUP:  rd_next = {4'h0, port3_pullup_reg};
            `MPF_SEL_P3_ALT:     rd_next = port3_alt_reg[11:4];
            `MPF_SEL_P5_LATCH:   rd_next = port_read({4'h0, port5_direction_reg},
                                                     {4'h0, port5_latch_reg}, {4'h0, p5_in});
            `MPF_SEL_P5_DIR:     rd_next = {4'h0, port5_direction_reg};
            `MPF_SEL_P6_CTRL:    rd_next = p6_in & ~port6_analog_reg;
            default:             rd_next = 8'h00;
        endcase
    end

    always @(posedge clk) begin
        if (rst_all) begin
            rd_data_reg <= 8'h00;
        end else if (ce) begin
            rd_data_reg <= rd_next;
        end
    end

endmodule

// ---- mpf_defines.vh ----
`ifndef MPF_DEFINES_VH
`define MPF_DEFINES_VH

// Register select codes for the write and read ports.
`define MPF_SEL_P0_LATCH     4'h0
`define MPF_SEL_P0_DIR       4'h1
`define MPF_SEL_P1_LATCH     4'h2
`define MPF_SEL_P1_DIR       4'h3
`define MPF_SEL_LOW_PULLUP   4'h4
`define MPF_SEL_P2_LATCH     4'h5
`define MPF_SEL_P2_DIR       4'h6
`define MPF_SEL_P2_PULLUP    4'h7
`define MPF_SEL_P2_ALT       4'h8
`define MPF_SEL_P3_LATCH     4'h9
`define MPF_SEL_P3_DIR       4'hA
`define MPF_SEL_P3_PULLUP    4'hB
`define MPF_SEL_P3_ALT       4'hC
`define MPF_SEL_P5_LATCH     4'hD
`define MPF_SEL_P5_DIR       4'hE
`define MPF_SEL_P6_CTRL      4'hF

// Field positions inside the shared low-port pull-up register.
`define MPF_LOWPU_P1_LSB     6
`define MPF_LOWPU_P1_MSB     7

// Field positions inside the port 3 alternate-function register.
`define MPF_P3ALT_EN_MSB     3
`define MPF_P3ALT_EDGE_LSB   4

// Open-drain bits of port 2.
`define MPF_P2_OD_SCL        3
`define MPF_P2_OD_SDA        4

// Reset value of every control register.
`define MPF_CTRL_RESET       8'h00

// Valid-edge encodings for the external interrupt inputs.
`define MPF_EDGE_NONE        2'h0
`define MPF_EDGE_RISE        2'h1
`define MPF_EDGE_FALL        2'h2
`define MPF_EDGE_BOTH        2'h3

`endif

// ---- mpf_edge_det.v ----
`include "mpf_defines.vh"

module mpf_edge_det #(
    parameter N = 4
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             ce,
    input  wire [N-1:0]     enable,
    input  wire [2*N-1:0]   edge_sel,
    input  wire [N-1:0]     level,
    output reg  [N-1:0]     pulse_reg
);

    reg  [N-1:0] prev_reg;
    reg  [N-1:0] pulse_next;
    integer      i;

    always @* begin
        pulse_next = {N{1'b0}};
        for (i = 0; i < N; i = i + 1) begin
            case (edge_sel[2*i +: 2])
                `MPF_EDGE_RISE: pulse_next[i] = enable[i] & level[i] & ~prev_reg[i];
                `MPF_EDGE_FALL: pulse_next[i] = enable[i] & ~level[i] & prev_reg[i];
                `MPF_EDGE_BOTH: pulse_next[i] = enable[i] & (level[i] ^ prev_reg[i]);
                default:        pulse_next[i] = 1'b0;
            endcase
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            prev_reg  <= {N{1'b0}};
            pulse_reg <= {N{1'b0}};
        end else if (ce) begin
            prev_reg  <= level;
            pulse_reg <= pulse_next;
        end
    end

endmodule

// ---- mpf_port_properties.sv ----
`include "mpf_defines.vh"

module mpf_port_properties (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       ce,
    input wire logic       sys_reset_n,
    input wire logic       wr_en,
    input wire logic [3:0] wr_sel,
    input wire logic [7:0] wr_data,
    input wire logic [3:0] rd_sel,
    input wire logic [7:0] rd_data_reg,
    input wire logic [5:0] p0_oe_n_reg,
    input wire logic [5:0] p0_pullup_reg,
    input wire logic [1:0] p1_oe_n_reg,
    input wire logic [6:0] p2_out_reg,
    input wire logic [6:0] p2_pullup_reg,
    input wire logic [3:0] p3_in,
    input wire logic [3:0] p3_oe_n_reg,
    input wire logic [3:0] p3_pullup_reg,
    input wire logic [3:0] p5_out_reg,
    input wire logic [7:0] p6_in,
    input wire logic [7:0] analog_in_sel_reg,
    input wire logic [3:0] ext_irq_in
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst || !sys_reset_n);

    // A write only shows if the cycle after it is neither frozen nor reset.
    wire ok = ce && !rst && sys_reset_n;

    sequence s_wr(logic [3:0] sel);
        ce && wr_en && wr_sel == sel;
    endsequence

    a_rst_clears: assert property (disable iff (1'b0)
        rst |=> p0_oe_n_reg == 6'h3F && p3_pullup_reg == 4'h0 && ext_irq_in == 4'h0)
        else $error("core reset left an output active");
    a_pin_reset: assert property (disable iff (1'b0)
        !sys_reset_n |=> rd_data_reg == 8'h00 && analog_in_sel_reg == 8'h00 && p3_oe_n_reg == 4'hF)
        else $error("reset pin did not clear outputs");
    a_p2_open_drain: assert property (p2_out_reg[4:3] == 2'b00 && p2_pullup_reg[4:3] == 2'b00)
        else $error("open-drain bit of port 2 driven high or pulled up");
    a_p5_open_drain: assert property (p5_out_reg == 4'h0)
        else $error("port 5 drives high");
    a_low_pullup_input: assert property ((p0_pullup_reg & ~p0_oe_n_reg) == 6'h00)
        else $error("port 0 pull-up on a driven bit");
    a_p0_dir_write: assert property (s_wr(`MPF_SEL_P0_DIR) ##1 ok |=>
        p0_oe_n_reg == ~$past(wr_data[5:0], 2)) else $error("port 0 direction write lost");
    a_p1_dir_write: assert property (s_wr(`MPF_SEL_P1_DIR) ##1 ok |=>
        p1_oe_n_reg == ~$past(wr_data[1:0], 2)) else $error("port 1 direction write lost");
    a_p3_dir_write: assert property (s_wr(`MPF_SEL_P3_DIR) ##1 ok |=>
        p3_oe_n_reg == ~$past(wr_data[3:0], 2)) else $error("port 3 direction write lost");
    a_p2_pullup_write: assert property (s_wr(`MPF_SEL_P2_PULLUP) ##1 ok |=>
        p2_pullup_reg == ($past(wr_data[6:0], 2) & 7'h67)) else $error("port 2 pull-up write lost");
    a_p3_pullup_write: assert property (s_wr(`MPF_SEL_P3_PULLUP) ##1 ok |=>
        p3_pullup_reg == $past(wr_data[3:0], 2)) else $error("port 3 pull-up write lost");
    a_p6_read_mask: assert property (ce && rd_sel == `MPF_SEL_P6_CTRL |=>
        rd_data_reg == ($past(p6_in) & ~analog_in_sel_reg)) else $error("port 6 read wrong");
    a_irq_has_cause: assert property (ext_irq_in[0] && $past(ce) && $past(ce, 2) |->
        $past(p3_in[0]) != $past(p3_in[0], 2)) else $error("interrupt pulse without pin edge");
endmodule

// ---- mpf_board_model.sv ----
module mpf_board_model #(
    parameter int       W       = 8
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] out,
    input  wire logic [W-1:0] oe_n,
    input  wire logic [W-1:0] pull_en,
    input  wire logic [W-1:0] ext_val,
    input  wire logic [W-1:0] ext_en,
    output logic      [W-1:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // An undriven line without any pull toggles every cycle, so a stale value never passes.
    logic [W-1:0] float_reg = '0;

    always @(posedge clk) begin
        float_reg <= ~float_reg;
    end

    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (!oe_n[i])
                pin[i] = out[i];
            else if (ext_en[i])
                pin[i] = ext_val[i];
            else if (pull_en[i])
                pin[i] = 1'b1;
            else
                pin[i] = float_reg[i];
        end
    end
endmodule

// ---- tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [3:0] LSEL [5] = '{4'h0, 4'h2, 4'h5, 4'h9, 4'hD};
    localparam logic [7:0] MASK [5] = '{8'h3F, 8'h03, 8'h7F, 8'h0F, 8'h0F};
    localparam logic [7:0] OD   [5] = '{8'h00, 8'h00, 8'h18, 8'h00, 8'h0F};
    localparam logic [7:0] CORN [4] = '{8'hFF, 8'h55, 8'hAA, 8'hF0};

    logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, sys_reset_n = 1'b1, wr_en = 1'b0;
    logic [3:0]  wr_sel = 4'h0, rd_sel = 4'h0;
    logic [7:0]  wr_data = 8'h00, p6_in = 8'h00, rd_data_reg, analog_in_sel_reg, d, a;
    logic [11:0] periph = 12'h000;
    logic [5:0]  p0_in, p0_out_reg, p0_oe_n_reg, p0_pullup_reg;
    logic [1:0]  p1_in, p1_out_reg, p1_oe_n_reg, p1_pullup_reg;
    logic [6:0]  p2_in, p2_out_reg, p2_oe_n_reg, p2_pullup_reg;
    logic [3:0]  p3_in, p3_out_reg, p3_oe_n_reg, p3_pullup_reg, p5_in, p5_out_reg, p5_oe_n_reg, ext_irq_in, seen;
    logic        sync_serial_clock_in_reg, async_clock_in_reg, sync_serial_data_in_reg, async_rx_reg;
    logic        two_wire_clock_in_reg, two_wire_data_in_reg, timer_a_ext_clock_in_reg;
    logic        sync_serial_select_in_reg, timer_b_ext_clock_in_reg, capture_edge_in_reg;
    wire         serial_async_sel, sync_serial_clock_out, sync_serial_data_out, async_tx, two_wire_clock_out;
    wire         two_wire_data_out, timer_a_out, timer_b_out, wide_timer_out, timer_c_out, buzzer_out, buzzer_sel;
    logic [7:0]  lat [5], dir [5], ev [5], ee [5], oe_v [5], out_v [5], pu [3];
    int          seed = 73, n_fail = 0, compares = 0, tot;

    assign {serial_async_sel, sync_serial_clock_out, sync_serial_data_out, async_tx, two_wire_clock_out,
            two_wire_data_out, timer_a_out, timer_b_out, wide_timer_out, timer_c_out, buzzer_out, buzzer_sel} = periph;
    assign oe_v = '{8'(p0_oe_n_reg), 8'(p1_oe_n_reg), 8'(p2_oe_n_reg), 8'(p3_oe_n_reg), 8'(p5_oe_n_reg)};
    assign out_v = '{8'(p0_out_reg), 8'(p1_out_reg), 8'(p2_out_reg), 8'(p3_out_reg), 8'(p5_out_reg)};

    mpf_port_logic mpf_port_logic_inst (.*);

    // The open-drain lines of ports 2 and 5 carry board pull-ups of their own.
    mpf_board_model #(.W(23)) board (.clk, .out({p5_out_reg, p3_out_reg, p2_out_reg, p1_out_reg, p0_out_reg}),
        .oe_n({p5_oe_n_reg, p3_oe_n_reg, p2_oe_n_reg, p1_oe_n_reg, p0_oe_n_reg}),
        .pull_en({4'hF, p3_pullup_reg, p2_pullup_reg | 7'h18, p1_pullup_reg, p0_pullup_reg}),
        .ext_val({ev[4][3:0], ev[3][3:0], ev[2][6:0], ev[1][1:0], ev[0][5:0]}),
        .ext_en({ee[4][3:0], ee[3][3:0], ee[2][6:0], ee[1][1:0], ee[0][5:0]}),
        .pin({p5_in, p3_in, p2_in, p1_in, p0_in}));

    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // The strobe stays up between back-to-back writes; callers drop it afterwards.
    task automatic wr(logic [3:0] sel, logic [7:0] v);
        wr_en = 1'b1;
        wr_sel = sel;
        wr_data = v;
        tick(1);
    endtask

    task automatic rd(logic [3:0] sel, output logic [7:0] v);
        rd_sel = sel;
        tick(1);
        v = rd_data_reg;
    endtask

    task automatic chk_reset;
        chk("drive enables", 32'h7FFFFF, {p0_oe_n_reg, p1_oe_n_reg, p2_oe_n_reg, p3_oe_n_reg, p5_oe_n_reg});
        chk("pulls", 32'h0, {p0_pullup_reg, p1_pullup_reg, p2_pullup_reg, p3_pullup_reg, analog_in_sel_reg});
    endtask

    function automatic logic [3:0] irq_exp(logic [7:0] v, int fall);
        for (int i = 0; i < 4; i++)
            irq_exp[i] = v[i] & v[2 * i + fall];
    endfunction

    task automatic irq_win(logic [7:0] lvl, logic [3:0] exp);
        ev[3] = lvl;
        seen = 4'h0;
        tot = 0;
        repeat (4) begin
            tick(1);
            seen |= ext_irq_in;
            tot += $countones(ext_irq_in);
        end
        chk("irq seen", exp, seen);
        chk("irq count", $countones(exp), tot);
    endtask

    task automatic close_out;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_fail++;
        close_out();
    end

    initial begin
        for (int p = 0; p < 5; p++) begin
            ev[p] = 8'h00;
            ee[p] = 8'h00;
        end
        tick(12);
        rst = 1'b0;
        chk_reset();
        $display("test reset values done");
        for (int r = 0; r < 10; r++) begin
            wr(4'h8, 8'h00);
            wr(4'hC, 8'h00);
            for (int p = 0; p < 5; p++) begin
                lat[p] = 8'($random(seed));
                dir[p] = (r == 0) ? 8'hFF : 8'($random(seed));
                ev[p] = 8'($random(seed));
                ee[p] = ~dir[p];
                wr(LSEL[p], lat[p]);
                wr(LSEL[p] + 4'h1, dir[p]);
            end
            for (int k = 0; k < 3; k++) begin
                pu[k] = 8'($random(seed));
                wr((k == 0) ? 4'h4 : (k == 1) ? 4'h7 : 4'hB, pu[k]);
            end
            wr_en = 1'b0;
            tick(2);
            for (int p = 0; p < 5; p++) begin
                chk("drive enable", ~(dir[p] & ~(OD[p] & lat[p])) & MASK[p], oe_v[p] & MASK[p]);
                chk("pin value", lat[p] & dir[p] & MASK[p] & ~OD[p], out_v[p] & dir[p] & MASK[p]);
                rd(LSEL[p], d);
                chk("port read", ((dir[p] & lat[p]) | (~dir[p] & ev[p])) & MASK[p], d & MASK[p]);
            end
            chk("low pulls", {pu[0][7:6] & ~dir[1][1:0], pu[0][5:0] & ~dir[0][5:0]}, {p1_pullup_reg, p0_pullup_reg});
            chk("port 2 pulls", pu[1] & 8'h67, p2_pullup_reg);
            chk("port 3 pulls", pu[2] & 8'h0F, p3_pullup_reg);
        end
        $display("test port modes done");
        ce = 1'b0;
        wr(4'h1, ~dir[0]);
        wr_en = 1'b0;
        ce = 1'b1;
        tick(2);
        chk("frozen write", ~dir[0] & 8'h3F, p0_oe_n_reg);
        $display("test frozen write done");
        wr(4'hA, 8'h00);
        ee[3] = 8'h0F;
        ev[3] = 8'h00;
        for (int r = 0; r < 8; r++) begin
            a = (r < 4) ? CORN[r] : 8'($random(seed));
            wr(4'hC, a);
            wr_en = 1'b0;
            tick(3);
            irq_win(8'h0F, irq_exp(a, 0));
            irq_win(8'h00, irq_exp(a, 1));
            chk("capture input", {2{~a[0]}}, {capture_edge_in_reg, timer_b_ext_clock_in_reg});
        end
        $display("test interrupt edges done");
        wr(4'h8, 8'h7F);
        wr(4'h6, 8'h5B);
        wr(4'hC, 8'h0F);
        wr(4'hA, 8'h0E);
        wr_en = 1'b0;
        ee[2] = 8'h24;
        ee[3] = 8'h01;
        for (int r = 0; r < 6; r++) begin
            periph = 12'($random(seed));
            ev[2] = 8'($random(seed));
            tick(3);
            chk("port 2 alt out", {timer_a_out, serial_async_sel ? async_tx : sync_serial_data_out,
                sync_serial_clock_out}, {p2_out_reg[6], p2_out_reg[1:0]});
            chk("two-wire", {2{two_wire_data_out, two_wire_clock_out}},
                {p2_oe_n_reg[4:3], two_wire_data_in_reg, two_wire_clock_in_reg});
            chk("port 2 alt in", {{2{ev[2][2]}}, {2{ev[2][5]}}, {2{sync_serial_clock_out}}}, {sync_serial_data_in_reg,
                async_rx_reg, sync_serial_select_in_reg, timer_a_ext_clock_in_reg, sync_serial_clock_in_reg,
                async_clock_in_reg});
            chk("port 3 alt out", {buzzer_sel ? buzzer_out : timer_c_out, wide_timer_out, timer_b_out},
                p3_out_reg[3:1]);
        end
        $display("test alternate functions done");
        for (int r = 0; r < 4; r++) begin
            rd_sel = 4'h0;
            a = (r == 0) ? 8'h00 : 8'($random(seed));
            p6_in = 8'($random(seed));
            wr(4'hF, a);
            wr_en = 1'b0;
            tick(2);
            rd(4'hF, d);
            chk("analog select", a, analog_in_sel_reg);
            chk("port 6 read", p6_in & ~a, d);
        end
        $display("test input port done");
        sys_reset_n = 1'b0;
        tick(1);
        sys_reset_n = 1'b1;
        tick(1);
        chk_reset();
        $display("test reset pin done");
        close_out();
    end
endmodule

bind mpf_port_logic mpf_port_properties mpf_port_properties_inst (.*);
